// >>> hdl/peripheral_irq_flags_bank1.sv
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module peripheral_irq_flags_bank1 (
	input wire logic clk_i,
	input wire logic rst_i,
	// classic wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// peripheral side
	input wire irq_flags_pkg::periph_events_t events_i,
	input wire logic [7:0] port_b_inputs_i,
	input wire logic tx_buffer_empty_i,
	input wire logic rx_buffer_full_i,
	output logic capture_or_period_select_o,
	output logic timer_pair_wide_select_o,
	output logic [7:0] flags_o
);

	logic access;
	logic wr_flags;
	logic wr_ctrl;
	logic wr_latch;
	logic mismatch;
	logic [7:0] latched;
	logic [1:0] ctrl_r;
	logic timer_c_set;
	logic timer_a_set;
	logic [5:0] set_vec;
	logic [5:0] flag_q;
	logic tx_r;
	logic rx_r;
	logic port_flag_r;
	logic [7:0] flags_rd;

	// bus decode, one write per acknowledged access on byte lane 0
	assign access = cyc_i & stb_i & ~ack_o;
	assign wr_flags = access & we_i & sel_i[0] & (adr_i == irq_flags_pkg::FLAGS_ADDR);
	assign wr_ctrl = access & we_i & sel_i[0] & (adr_i == irq_flags_pkg::CTRL_ADDR);
	assign wr_latch = access & we_i & sel_i[0] & (adr_i == irq_flags_pkg::LATCH_ADDR);

	// acknowledge one cycle after request, drop the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= access;
		end
	end

	// mode control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= irq_flags_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r <= dat_i[1:0];
		end
	end

	assign capture_or_period_select_o = ctrl_r[irq_flags_pkg::CAPTURE_OR_PERIOD_BIT];
	assign timer_pair_wide_select_o = ctrl_r[irq_flags_pkg::TIMER_PAIR_WIDE_BIT];

	// port change detector; writing the latch register ends the mismatch
	port_change_detect u_port (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.port_i(port_b_inputs_i),
		.latch_i(wr_latch),
		.latched_o(latched),
		.mismatch_o(mismatch)
	);

	// port change flag: not cleared by reset, so it starts as whatever it held
	always_ff @(posedge clk_i) begin
		if (mismatch) begin
			port_flag_r <= 1'b1;
		end else if (wr_flags) begin
			port_flag_r <= dat_i[irq_flags_pkg::PORT_CHANGE_BIT];
		end
	end

	// source selection for the timer flags
	assign timer_c_set = ctrl_r[irq_flags_pkg::CAPTURE_OR_PERIOD_BIT]
		? events_i.timer_c_overflow
		: events_i.timer_c_period_wrap;
	assign timer_a_set = ctrl_r[irq_flags_pkg::TIMER_PAIR_WIDE_BIT]
		? events_i.pair_wrap
		: events_i.timer_a_wrap;

	assign set_vec = {timer_c_set, events_i.timer_b_wrap, timer_a_set,
		events_i.capture_second, events_i.capture_first, 1'b0};

	// sticky writable flags, bits 6..2, cleared at reset
	genvar g;
	generate
		for (g = 2; g <= 6; g++) begin : g_flag
			flag_bit u_flag (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.set_i(set_vec[g-1]),
				.wr_i(wr_flags),
				.wdata_i(dat_i[g]),
				.q_o(flag_q[g-1])
			);
		end
	endgenerate
	assign flag_q[0] = 1'b0;

	// serial status mirrors, write ignored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_r <= irq_flags_pkg::FLAGS_RESET[irq_flags_pkg::TX_EMPTY_BIT];
			rx_r <= irq_flags_pkg::FLAGS_RESET[irq_flags_pkg::RX_FULL_BIT];
		end else begin
			tx_r <= tx_buffer_empty_i;
			rx_r <= rx_buffer_full_i;
		end
	end

	assign flags_rd = {port_flag_r, flag_q[5:1], tx_r, rx_r};
	assign flags_o = flags_rd;

	// read data, registered with the acknowledge; unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (access) begin
			unique case (adr_i)
				irq_flags_pkg::FLAGS_ADDR: dat_o <= {24'h00_0000, flags_rd};
				irq_flags_pkg::CTRL_ADDR: dat_o <= {30'h0000_0000, ctrl_r};
				irq_flags_pkg::LATCH_ADDR: dat_o <= {24'h00_0000, latched};
				default: dat_o <= 32'h0000_0000;
			endcase
		end
	end

endmodule

`default_nettype wire

// >>> hdl/irq_flags_pkg.sv
package irq_flags_pkg;

	// register indices as printed, byte address is four times the index
	localparam logic [7:0] FLAGS_IDX = 8'h16;
	localparam logic [7:0] CTRL_IDX = 8'h18;
	localparam logic [7:0] LATCH_IDX = 8'h19;
	localparam logic [9:0] FLAGS_ADDR = {FLAGS_IDX, 2'b00};
	localparam logic [9:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
	localparam logic [9:0] LATCH_ADDR = {LATCH_IDX, 2'b00};

	// flag bit positions
	localparam int PORT_CHANGE_BIT = 7;
	localparam int TIMER_C_BIT = 6;
	localparam int TIMER_B_BIT = 5;
	localparam int TIMER_A_BIT = 4;
	localparam int CAPTURE_SECOND_BIT = 3;
	localparam int CAPTURE_FIRST_BIT = 2;
	localparam int TX_EMPTY_BIT = 1;
	localparam int RX_FULL_BIT = 0;

	// control register fields
	localparam int CAPTURE_OR_PERIOD_BIT = 0;
	localparam int TIMER_PAIR_WIDE_BIT = 1;

	// values after reset, and the mask of writable flag bits
	localparam logic [7:0] FLAGS_RESET = 8'h02;
	localparam logic [7:0] WRITABLE_MASK = 8'hFC;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [7:0] LATCH_RESET = 8'h00;

	// one-cycle peripheral events bundled together
	typedef struct packed {
		logic timer_c_overflow;
		logic timer_c_period_wrap;
		logic timer_a_wrap;
		logic timer_b_wrap;
		logic pair_wrap;
		logic capture_second;
		logic capture_first;
	} periph_events_t;

endpackage

// >>> hdl/flag_bit.sv
`timescale 1ns/1ps
`default_nettype none

// one sticky flag: hardware set wins over a software write
module flag_bit (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic set_i,
	input wire logic wr_i,
	input wire logic wdata_i,
	output logic q_o
);

	// sticky storage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_o <= 1'b0;
		end else if (set_i) begin
			q_o <= 1'b1;
		end else if (wr_i) begin
			q_o <= wdata_i;
		end
	end

endmodule

`default_nettype wire

// >>> hdl/port_change_detect.sv
`timescale 1ns/1ps
`default_nettype none

// compares port inputs to a latched copy; latch is refreshed by software
module port_change_detect (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] port_i,
	input wire logic latch_i,
	output logic [7:0] latched_o,
	output logic mismatch_o
);

	// latched copy of the port, taken on a software request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latched_o <= irq_flags_pkg::LATCH_RESET;
		end else if (latch_i) begin
			latched_o <= port_i;
		end
	end

	// level mismatch, held while any input differs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mismatch_o <= 1'b0;
		end else begin
			mismatch_o <= |(port_i ^ latched_o);
		end
	end

endmodule

`default_nettype wire

// >>> bench/irq_flags_props.sv
`timescale 1ns/1ps
`default_nettype none
module irq_flags_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire irq_flags_pkg::periph_events_t events_i,
	input wire logic tx_buffer_empty_i,
	input wire logic capture_or_period_select_o,
	input wire logic timer_pair_wide_select_o,
	input wire logic [7:0] flags_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// bus answer is a single pulse
	sequence ack_pulse;
		ack_o ##1 !ack_o;
	endsequence
	chk_ack_single: assert property (cyc_i && stb_i && !ack_o |=> ack_pulse)
		else $error("bad answer");
	chk_cap_one: assert property (events_i.capture_first |=> flags_o[2])
		else $error("cap1 flag");
	chk_cap_two: assert property (events_i.capture_second |=> flags_o[3])
		else $error("cap2 flag");
	chk_timer_b: assert property (events_i.timer_b_wrap |=> flags_o[5])
		else $error("tb flag");
	chk_timer_c_ovf: assert property (events_i.timer_c_overflow && capture_or_period_select_o |=> flags_o[6])
		else $error("tc ovf");
	chk_timer_c_per: assert property (events_i.timer_c_period_wrap && !capture_or_period_select_o |=> flags_o[6])
		else $error("tc wrap");
	chk_timer_a_narrow: assert property (events_i.timer_a_wrap && !timer_pair_wide_select_o |=> flags_o[4])
		else $error("ta flag");
	chk_timer_a_wide: assert property (events_i.pair_wrap && timer_pair_wide_select_o |=> flags_o[4])
		else $error("pair flag");
	chk_tx_mirror: assert property (!$past(rst_i) |-> flags_o[1] == $past(tx_buffer_empty_i))
		else $error("tx flag");
endmodule
bind peripheral_irq_flags_bank1 irq_flags_props u_props (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .events_i(events_i), .flags_o(flags_o),
	.tx_buffer_empty_i(tx_buffer_empty_i), .timer_pair_wide_select_o(timer_pair_wide_select_o),
	.capture_or_period_select_o(capture_or_period_select_o));
`default_nettype wire

// >>> bench/periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module periph_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire irq_flags_pkg::periph_events_t fire_i,
	output var irq_flags_pkg::periph_events_t events_o
);
	// requests leave as registered event pulses
	always_ff @(posedge clk_i) begin
		events_o <= rst_i ? '0 : fire_i;
	end
endmodule
`default_nettype wire

// >>> bench/peripheral_irq_flags_bank1_tb.sv
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flags_bank1_tb;
	localparam logic [9:0] fa = irq_flags_pkg::FLAGS_ADDR;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic we = 1'h0;
	logic tx = 1'h1;
	logic rx = 1'h0;
	logic ack;
	logic [9:0] adr = 10'h000;
	logic [31:0] wd = 32'h00000000;
	logic [31:0] rd;
	logic [31:0] q;
	logic [7:0] port = 8'h00;
	irq_flags_pkg::periph_events_t fire = 7'h00;
	irq_flags_pkg::periph_events_t ev;
	logic [7:0] fl;
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	always #12.5 clk_i = ~clk_i;
	peripheral_irq_flags_bank1 dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wd), .dat_o(rd), .ack_o(ack),
		.events_i(ev), .port_b_inputs_i(port), .tx_buffer_empty_i(tx), .rx_buffer_full_i(rx),
		.capture_or_period_select_o(), .timer_pair_wide_select_o(), .flags_o(fl));
	periph_model u_src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .events_o(ev));
	// one classic bus cycle, held until answered
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, wd} <= {2'h3, w, a, d};
		do @(posedge clk_i); while (ack !== 1'h1);
		q = rd;
		{cyc, stb} <= 2'h0;
	endtask
	task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task print_verdict;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// flags 6..2 expected for event i under control c
	function automatic logic [4:0] expect_flags(input logic [1:0] c, input int i);
		case (i)
			6: return c[0] ? 5'h10 : 5'h00;
			5: return c[0] ? 5'h00 : 5'h10;
			4: return c[1] ? 5'h00 : 5'h04;
			3: return 5'h08;
			2: return c[1] ? 5'h04 : 5'h00;
			1: return 5'h02;
			default: return 5'h01;
		endcase
	endfunction
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 2000) begin
			errors++;
			print_verdict;
		end
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'h0;
		bus(1'h0, fa, 32'h0);
		check("reset", {1'h0, q[6:0]}, 8'h02);
		bus(1'h0, 10'h3FC, 32'h0);
		check("unmapped", q[7:0], 8'h00);
		for (int c = 0; c < 4; c += 3) begin
			bus(1'h1, irq_flags_pkg::CTRL_ADDR, c);
			for (int i = 0; i < 7; i++) begin
				bus(1'h1, fa, 32'h0);
				fire <= irq_flags_pkg::periph_events_t'(7'(7'h01 << i));
				@(posedge clk_i);
				fire <= 7'h00;
				bus(1'h0, fa, 32'h0);
				check("event", q[6:2], expect_flags(c[1:0], i));
			end
		end
		{tx, rx} <= 2'h1;
		bus(1'h1, fa, 32'h000000FF);
		bus(1'h0, fa, 32'h0);
		check("write all", q[7:0], 8'hFD);
		bus(1'h1, fa, 32'h0);
		bus(1'h0, fa, 32'h0);
		check("clear all", q[7:0], 8'h01);
		port <= 8'h01;
		bus(1'h1, fa, 32'h0);
		bus(1'h0, fa, 32'h0);
		check("port change", q[7:0], 8'h81);
		bus(1'h1, irq_flags_pkg::LATCH_ADDR, 32'h0);
		bus(1'h1, fa, 32'h0);
		bus(1'h0, fa, 32'h0);
		check("port settled", q[7:0], 8'h01);
		check("flags pins", fl, 8'h01);
		print_verdict;
	end
endmodule
`default_nettype wire
